// [rtl/exc_pkg.sv]
// Shared constants of the exception and status word logic
`default_nettype none
package exc_pkg;
  localparam int unsigned XLEN    = 32;
  localparam int unsigned NBANK   = 5;
  localparam int unsigned CLASS_W = 3;
  localparam int unsigned PHYS_W  = 5;

  // Status word layout
  localparam int unsigned SW_N       = 31;
  localparam int unsigned SW_V       = 28;
  localparam int unsigned SW_I       = 7;
  localparam int unsigned SW_F       = 6;
  localparam int unsigned SW_T       = 5;
  localparam int unsigned SW_MODE_HI = 4;
  localparam int unsigned SW_MODE_LO = 0;

  localparam logic [4:0] MODE_FAST = 5'h11;
  localparam logic [4:0] MODE_IRQ = 5'h12;
  localparam logic [4:0] MODE_SVC = 5'h13;
  localparam logic [4:0] MODE_ABT = 5'h17;
  localparam logic [4:0] MODE_UND = 5'h1b;
  localparam logic [XLEN-1:0] RESET_STATUS = 32'h0000_00d3;

  // Index of each banked link register / saved status word
  localparam logic [2:0] BK_FAST = 3'h0;
  localparam logic [2:0] BK_IRQ = 3'h1;
  localparam logic [2:0] BK_ABT = 3'h2;
  localparam logic [2:0] BK_UND = 3'h3;
  localparam logic [2:0] BK_SVC = 3'h4;

  localparam logic [XLEN-1:0] VEC_UND = 32'h0000_0004;
  localparam logic [XLEN-1:0] VEC_TRAP = 32'h0000_0008;
  localparam logic [XLEN-1:0] VEC_ABT = 32'h0000_0010;
  localparam logic [XLEN-1:0] VEC_IRQ = 32'h0000_0018;
  localparam logic [XLEN-1:0] VEC_FAST = 32'h0000_001c;

  // Instruction classes
  localparam logic [CLASS_W-1:0] CL_BRANCH = 3'h0;
  localparam logic [CLASS_W-1:0] CL_DP     = 3'h1;
  localparam logic [CLASS_W-1:0] CL_SWX    = 3'h2;
  localparam logic [CLASS_W-1:0] CL_LS     = 3'h3;
  localparam logic [CLASS_W-1:0] CL_COP    = 3'h4;
  localparam logic [CLASS_W-1:0] CL_EXC    = 3'h5;
  localparam logic [CLASS_W-1:0] CL_LSM    = 3'h6;
  localparam logic [CLASS_W-1:0] CL_UNDEF  = 3'h7;

  // Instruction fields
  localparam int unsigned COND_HI = 31;
  localparam int unsigned COND_LO = 28;
  localparam int unsigned INS_S   = 20;
  localparam int unsigned INS_RS  = 22;
  localparam int unsigned INS_PCL = 15;
  localparam int unsigned RD_HI   = 15;
  localparam int unsigned RD_LO   = 12;
  localparam int unsigned INS_CTL_WR = 21;
  localparam int unsigned INS_CTL_F  = 16;
  localparam logic [3:0]  COND_NEVER  = 4'hf;
  localparam logic [23:0] BX_PATTERN  = 24'h12_fff1;
  localparam logic [3:0]  T_COND_TRAP = 4'hf;
  localparam logic [3:0]  T_COND_UND  = 4'he;

  // Register numbers and physical register file layout
  localparam logic [3:0] REG_LOW_TOP = 4'h7;
  localparam logic [3:0] REG_BANK_LO = 4'h8;
  localparam logic [3:0] REG_BANK_HI = 4'hc;
  localparam logic [3:0] REG_SP      = 4'hd;
  localparam logic [3:0] REG_LR      = 4'he;
  localparam logic [3:0] REG_PC      = 4'hf;
  localparam logic [PHYS_W-1:0] PR_FAST = 5'h10;
  localparam logic [PHYS_W-1:0] PR_SVC = 5'h17;
  localparam logic [PHYS_W-1:0] PR_ABT = 5'h19;
  localparam logic [PHYS_W-1:0] PR_IRQ = 5'h1b;
  localparam logic [PHYS_W-1:0] PR_UND = 5'h1d;
endpackage : exc_pkg
`default_nettype wire

// [rtl/bank_reg_map.sv]
// Logical register number to physical register file index
`default_nettype none
module bank_reg_map (
  input  wire logic [3:0]                 reg_idx_i,
  input  wire logic [4:0]                 mode_i,
  input  wire logic                       narrow_i,
  input  wire logic                       hi_reg_op_i,
  output logic [exc_pkg::PHYS_W-1:0]      phys_o,
  output logic                            allowed_o
);
  import exc_pkg::*;

  logic [PHYS_W-1:0] base;

  always_comb
  begin
    base = PR_SVC;
    case (mode_i)
      MODE_ABT: base = PR_ABT;
      MODE_IRQ: base = PR_IRQ;
      MODE_UND: base = PR_UND;
      default:  base = PR_SVC;
    endcase
  end

  always_comb
  begin
    phys_o = {1'b0, reg_idx_i};
    if (mode_i == MODE_FAST && reg_idx_i >= REG_BANK_LO && reg_idx_i <= REG_LR)
      phys_o = PR_FAST + {1'b0, reg_idx_i - REG_BANK_LO};
    else if ((reg_idx_i == REG_SP || reg_idx_i == REG_LR)
             && (mode_i == MODE_SVC || mode_i == MODE_ABT
                 || mode_i == MODE_IRQ || mode_i == MODE_UND))
      phys_o = base + {1'b0, reg_idx_i - REG_SP};
  end

  assign allowed_o = !narrow_i || reg_idx_i <= REG_LOW_TOP || reg_idx_i >= REG_SP || hi_reg_op_i;
endmodule : bank_reg_map
`default_nettype wire

// [rtl/exc_unit.sv]
// Exception entry and return, status word and instruction class logic
`default_nettype none
module exc_unit (
  input  wire logic                          clk_i,
  input  wire logic                          rstn_i,
  input  wire logic                          fast_interrupt_req_i,
  input  wire logic                          irq_req_i,
  input  wire logic                          abort_i,
  input  wire logic                          undef_i,
  input  wire logic                          instr_valid_i,
  input  wire logic [exc_pkg::XLEN-1:0]      instr_i,
  input  wire logic [exc_pkg::XLEN-1:0]      return_addr_i,
  input  wire logic [3:0]                    reg_idx_i,
  input  wire logic                          hi_reg_op_i,
  output logic [exc_pkg::XLEN-1:0]           current_status_word_o,
  output logic [exc_pkg::XLEN-1:0]           saved_status_word_o,
  output logic [exc_pkg::XLEN-1:0]           link_register_o,
  output logic                               pc_load_o,
  output logic [exc_pkg::XLEN-1:0]           pc_target_o,
  output logic                               exc_taken_o,
  output logic                               instr_exec_o,
  output logic [exc_pkg::CLASS_W-1:0]        instr_class_o,
  output logic [exc_pkg::PHYS_W-1:0]         phys_reg_o,
  output logic                               reg_allowed_o
);
  import exc_pkg::*;

  logic [2:0]         fast_sync;
  logic [2:0]         irq_sync;
  logic               fast_lvl;
  logic               irq_lvl;
  logic               pend_abt;
  logic               pend_und;
  logic               pend_trap;
  logic [XLEN-1:0]    saved_status_word [NBANK];
  logic [XLEN-1:0]    link_register [NBANK];
  logic [3:0]         cur_bank_v;
  logic [2:0]         cur_bank;
  logic               cur_banked;
  logic [XLEN-1:0]    ret_status;
  logic [XLEN-1:0]    ret_link;
  logic [CLASS_W-1:0] cls;
  logic               cond_pass;
  logic               dp_ret;
  logic               lm_ret;
  logic               ctl_wr;
  logic               exec_ok;
  logic               do_ret;
  logic               take_abt;
  logic               take_fast;
  logic               take_irq;
  logic               take_und;
  logic               take_trap;
  logic               take_any;
  logic [2:0]         next_bank;
  logic [4:0]         next_mode;
  logic [XLEN-1:0]    next_vector;
  logic [PHYS_W-1:0]  map_phys;
  logic               map_ok;
  logic [4:0]         cur_mode;

  function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
    logic r;
    case (c[3:1])
      3'h0: r = f[2];
      3'h1: r = f[1];
      3'h2: r = f[3];
      3'h3: r = f[0];
      3'h4: r = f[1] & ~f[2];
      3'h5: r = f[3] == f[0];
      3'h6: r = ~f[2] & (f[3] == f[0]);
      3'h7: r = 1'b1;
    endcase
    return (c == COND_NEVER) ? 1'b0 : (r ^ c[0]);
  endfunction : cond_ok

  function automatic logic [3:0] bank_of(input logic [4:0] m);
    case (m)
      MODE_FAST: return {1'b1, BK_FAST};
      MODE_IRQ: return {1'b1, BK_IRQ};
      MODE_ABT: return {1'b1, BK_ABT};
      MODE_UND: return {1'b1, BK_UND};
      MODE_SVC: return {1'b1, BK_SVC};
      default:  return 4'h0;
    endcase
  endfunction : bank_of

  // Interrupt lines come from another domain; a change counts once stages agree
  // external request sync
  always_ff @(posedge clk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      fast_sync <= 3'h0;
      irq_sync  <= 3'h0;
      fast_lvl  <= 1'b0;
      irq_lvl  <= 1'b0;
    end
    else
    begin
      fast_sync <= {fast_sync[1:0], fast_interrupt_req_i};
      irq_sync <= {irq_sync[1:0], irq_req_i};
      if (fast_sync[1] == fast_sync[2])
        fast_lvl <= fast_sync[2];
      if (irq_sync[1] == irq_sync[2])
        irq_lvl <= irq_sync[2];
    end

  assign cur_mode   = current_status_word_o[SW_MODE_HI:SW_MODE_LO];
  assign cur_bank_v = bank_of(cur_mode);
  assign cur_bank   = cur_bank_v[2:0];
  assign cur_banked = cur_bank_v[3];
  assign ret_status = saved_status_word[cur_bank];
  assign ret_link   = link_register[cur_bank];

  always_comb
  begin
    cls       = CL_DP;
    dp_ret    = 1'b0;
    lm_ret    = 1'b0;
    ctl_wr    = 1'b0;
    cond_pass = 1'b1;
    if (current_status_word_o[SW_T])
    begin
      casez (instr_i[15:11])
        5'b01001, 5'b0101?, 5'b011??, 5'b100??: cls = CL_LS;
        5'b1011?: cls = instr_i[10] ? CL_LSM : CL_DP;
        5'b1100?: cls = CL_LSM;
        5'b1101?:
        begin
          if (instr_i[11:8] == T_COND_TRAP)
            cls = CL_EXC;
          else if (instr_i[11:8] == T_COND_UND)
            cls = CL_UNDEF;
          else
          begin
            cls       = CL_BRANCH;
            cond_pass = cond_ok(instr_i[11:8], current_status_word_o[SW_N:SW_V]);
          end
        end
        5'b11100, 5'b1111?: cls = CL_BRANCH;
        5'b11101: cls = CL_UNDEF;
        default: cls = CL_DP;
      endcase
    end
    else
    begin
      cond_pass = cond_ok(instr_i[COND_HI:COND_LO], current_status_word_o[SW_N:SW_V]);
      case (instr_i[27:25])
        3'h0, 3'h1:
        begin
          if (instr_i[27:4] == BX_PATTERN)
            cls = CL_BRANCH;
          else if (instr_i[24:23] == 2'h2 && !instr_i[INS_S]
                   && (instr_i[25] || instr_i[7:4] == 4'h0))
          begin
            cls    = CL_SWX;
            // Only way to clear the masks outside a return, so interrupts can be reached
            ctl_wr = instr_i[25] && instr_i[INS_CTL_WR] && !instr_i[INS_RS]
                     && instr_i[INS_CTL_F] && instr_i[11:8] == 4'h0;
          end
          else if (!instr_i[25] && instr_i[7] && instr_i[4] && instr_i[6:5] != 2'h0)
            cls = CL_LS;
          else
          begin
            cls    = CL_DP;
            dp_ret = instr_i[INS_S] && instr_i[RD_HI:RD_LO] == REG_PC
                     && !(!instr_i[25] && instr_i[7] && instr_i[4]);
          end
        end
        3'h2: cls = CL_LS;
        3'h3: cls = instr_i[4] ? CL_UNDEF : CL_LS;
        3'h4:
        begin
          cls     = CL_LS;
          lm_ret  = instr_i[INS_S] && instr_i[INS_RS] && instr_i[INS_PCL];
        end
        3'h5: cls = CL_BRANCH;
        3'h6: cls = CL_COP;
        3'h7: cls = instr_i[24] ? CL_EXC : CL_COP;
      endcase
    end
  end

  // Any pending trap stalls execution so the trapping instruction is retried after return
  assign exec_ok = instr_valid_i && !take_any && !pend_abt && !pend_und && !pend_trap;
  // return when a banked mode exists
  assign do_ret  = exec_ok && cond_pass && (dp_ret || lm_ret) && cur_banked;

  always_comb
  begin
    take_abt    = pend_abt;
    take_fast   = !take_abt && fast_lvl && !current_status_word_o[SW_F];
    take_irq    = !take_abt && !take_fast && irq_lvl && !current_status_word_o[SW_I];
    take_und    = !(take_abt || take_fast || take_irq) && pend_und;
    take_trap   = !(take_abt || take_fast || take_irq || take_und) && pend_trap;
    take_any    = take_abt || take_fast || take_irq || take_und || take_trap;
    next_bank   = BK_SVC;
    next_mode   = MODE_SVC;
    next_vector = VEC_TRAP;
    if (take_abt)
    begin
      next_bank   = BK_ABT;
      next_mode   = MODE_ABT;
      next_vector = VEC_ABT;
    end
    else if (take_fast)
    begin
      next_bank   = BK_FAST;
      next_mode   = MODE_FAST;
      next_vector = VEC_FAST;
    end
    else if (take_irq)
    begin
      next_bank   = BK_IRQ;
      next_mode   = MODE_IRQ;
      next_vector = VEC_IRQ;
    end
    else if (take_und)
    begin
      next_bank   = BK_UND;
      next_mode   = MODE_UND;
      next_vector = VEC_UND;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      pend_abt <= 1'b0;
      pend_und <= 1'b0;
      pend_trap <= 1'b0;
    end
    else
    begin
      pend_abt <= abort_i || (pend_abt && !take_abt);
      pend_und <= undef_i || (exec_ok && cond_pass && cls == CL_UNDEF)
                  || (pend_und && !take_und);
      pend_trap <= (exec_ok && cond_pass && cls == CL_EXC) || (pend_trap && !take_trap);
    end

  for (genvar b = 0; b < NBANK; b++)
  begin : g_bank
    always_ff @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
      begin
        saved_status_word[b] <= '0;
        link_register[b]     <= '0;
      end
      else if (take_any && next_bank == 3'(b))
      begin
        saved_status_word[b] <= current_status_word_o;
        link_register[b]     <= return_addr_i;
      end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
    if (!rstn_i)
      current_status_word_o <= RESET_STATUS;
    else if (take_any)
    begin
      current_status_word_o[SW_MODE_HI:SW_MODE_LO] <= next_mode;
      current_status_word_o[SW_I] <= 1'b1;
      current_status_word_o[SW_T] <= 1'b0;
      if (take_fast)
        current_status_word_o[SW_F] <= 1'b1;
    end
    else if (do_ret)
      current_status_word_o <= ret_status;
    else if (exec_ok && cond_pass && ctl_wr && cur_banked)
      current_status_word_o[SW_I:SW_MODE_LO] <= instr_i[SW_I:SW_MODE_LO];

  always_ff @(posedge clk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      exc_taken_o  <= 1'b0;
      pc_load_o    <= 1'b0;
      pc_target_o  <= '0;
      instr_exec_o <= 1'b0;
      instr_class_o <= CL_DP;
    end
    else
    begin
      exc_taken_o   <= take_any;
      pc_load_o     <= take_any || do_ret;
      instr_exec_o  <= exec_ok && cond_pass;
      instr_class_o <= cls;
      if (take_any)
        pc_target_o <= next_vector;
      else if (do_ret)
        pc_target_o <= ret_link;
    end

  bank_reg_map u_map (
    .reg_idx_i   (reg_idx_i),
    .mode_i      (cur_mode),
    .narrow_i    (current_status_word_o[SW_T]),
    .hi_reg_op_i (hi_reg_op_i),
    .phys_o      (map_phys),
    .allowed_o   (map_ok)
  );

  // Views lag the status word by one cycle; they are registered for timing
  always_ff @(posedge clk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      saved_status_word_o <= '0;
      link_register_o     <= '0;
      phys_reg_o          <= '0;
      reg_allowed_o       <= 1'b0;
    end
    else
    begin
      saved_status_word_o <= cur_banked ? ret_status : '0;
      link_register_o     <= cur_banked ? ret_link : '0;
      phys_reg_o          <= map_phys;
      reg_allowed_o       <= map_ok;
    end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence seq_abort_pend;
    abort_i ##1 pend_abt;
  endsequence
  sequence seq_abort_enter;
    exc_taken_o && pc_target_o == VEC_ABT && cur_mode == MODE_ABT;
  endsequence

  AST_FAST_ENTRY: assert property (
    take_fast |=> cur_mode == MODE_FAST && current_status_word_o[SW_F]
                 && pc_target_o == VEC_FAST)
    else $error("fast interrupt entry wrong");
  AST_ABORT_ENTRY: assert property (
    seq_abort_pend |=> seq_abort_enter)
    else $error("abort not entered two cycles after request");
  AST_PEND_KEPT: assert property (
    pend_und && (take_abt || take_fast || take_irq) |=> pend_und)
    else $error("undefined trap lost behind higher request");
  AST_BANK_SAVE: assert property (
    take_irq |=> saved_status_word[BK_IRQ] == $past(current_status_word_o)
                 && link_register[BK_IRQ] == $past(return_addr_i)
                 && $stable(link_register[BK_FAST]))
    else $error("entry saved into wrong bank");
  AST_RET_RESTORE: assert property (
    do_ret |=> current_status_word_o == $past(ret_status) && pc_load_o
               && pc_target_o == $past(ret_link))
    else $error("return did not restore state");
  AST_DP_RET: assert property (
    exec_ok && cond_pass && dp_ret && cur_banked |=> pc_load_o && !exc_taken_o)
    else $error("status-setting PC write did not return");
  AST_LM_RET: assert property (
    exec_ok && cond_pass && lm_ret && cur_banked |=> pc_load_o && !exc_taken_o)
    else $error("restore load multiple did not return");
  AST_COND_FAIL: assert property (
    exec_ok && !cond_pass |=> !instr_exec_o && !pc_load_o)
    else $error("failed condition still executed");
  AST_WIDE_BRANCH: assert property (
    !current_status_word_o[SW_T] && instr_i[27:25] == 3'h5 |=> instr_class_o == CL_BRANCH)
    else $error("32-bit branch misclassified");
  AST_NARROW_TRAP: assert property (
    current_status_word_o[SW_T] && instr_i[15:12] == 4'hd && instr_i[11:8] == T_COND_TRAP
    |=> instr_class_o == CL_EXC)
    else $error("16-bit trap misclassified");
  AST_LOW_SHARED: assert property (
    reg_idx_i <= REG_LOW_TOP |=> phys_reg_o[3:0] == $past(reg_idx_i) && !phys_reg_o[4])
    else $error("low register not shared");
  AST_NARROW_HI: assert property (
    current_status_word_o[SW_T] && reg_idx_i >= REG_BANK_LO && reg_idx_i <= REG_BANK_HI
    && !hi_reg_op_i |=> !reg_allowed_o)
    else $error("narrow state reached high register");
  AST_ENTRY_STATE: assert property (
    take_any |=> current_status_word_o[SW_I] && !current_status_word_o[SW_T])
    else $error("entry status bits wrong");
  AST_FAST_BANKED: assert property (
    cur_mode == MODE_FAST && reg_idx_i >= REG_BANK_LO && reg_idx_i <= REG_BANK_HI
    |=> phys_reg_o >= PR_FAST)
    else $error("fast interrupt register not banked");
  AST_IRQ_MASKED: assert property (
    current_status_word_o[SW_I] [*2] |-> !(exc_taken_o && pc_target_o == VEC_IRQ))
    else $error("masked interrupt taken");
endmodule : exc_unit
`default_nettype wire

// [dv/exc_partner.sv]
// Model of the interrupt controller and memory system facing the core
`default_nettype none
module exc_partner (
  input  wire logic clk_i,
  output logic      fast_interrupt_req_o,
  output logic      irq_req_o,
  output logic      abort_o,
  output logic      undef_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    fast_interrupt_req_o = 1'b0;
    irq_req_o = 1'b0;
    abort_o = 1'b0;
    undef_o = 1'b0;
  end
  // external pulsed requests
  // One clock is enough: the core latches aborts and undefined requests
  task automatic pulse(input logic abt, input logic und);
    abort_o = abt;
    undef_o = und;
    @(posedge clk_i);
    #1;
    abort_o = 1'b0;
    undef_o = 1'b0;
  endtask : pulse
  task automatic levels(input logic fast, input logic norm);
    fast_interrupt_req_o = fast;
    irq_req_o = norm;
  endtask : levels
endmodule : exc_partner
`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for the exception unit
`default_nettype none
module tb;
  import exc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        fast_req, irq, abt, und, pcl, taken, exec, allowed;
  logic        instr_valid_i = 1'b0;
  logic [31:0] instr_i = '0;
  logic [31:0] return_addr_i = '0;
  logic [3:0]  reg_idx_i = '0;
  logic [31:0] csw, ssw, link, pct, ret, m_sw;
  logic [31:0] m_saved [5];
  logic        hi_op = 1'b0;
  logic [31:0] m_link [5];
  logic [2:0]  cls;
  logic [4:0]  phys;
  int          bad_count = 0;
  int          n_checks = 0;
  int          cycles = 0;
  logic [31:0] ins_tab [5] = '{32'hea00_0000, 32'he081_0002, 32'he10f_0000,
                               32'he590_0000, 32'hee00_0000};
  logic [2:0]  cls_tab [5] = '{CL_BRANCH, CL_DP, CL_SWX, CL_LS, CL_COP};

  always #2.5 clk_i = ~clk_i;

  exc_partner part (.clk_i(clk_i), .fast_interrupt_req_o(fast_req), .irq_req_o(irq),
    .abort_o(abt), .undef_o(und));

  exc_unit DUT (.clk_i(clk_i), .rstn_i(rstn_i), .fast_interrupt_req_i(fast_req),
    .irq_req_i(irq), .abort_i(abt), .undef_i(und), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .return_addr_i(return_addr_i), .reg_idx_i(reg_idx_i),
    .hi_reg_op_i(hi_op), .current_status_word_o(csw), .saved_status_word_o(ssw),
    .link_register_o(link), .pc_load_o(pcl), .pc_target_o(pct), .exc_taken_o(taken),
    .instr_exec_o(exec), .instr_class_o(cls), .phys_reg_o(phys), .reg_allowed_o(allowed));

  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask : tick

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  function automatic int bank_of(input logic [4:0] md);
    case (md)
      MODE_FAST: return BK_FAST;
      MODE_IRQ: return BK_IRQ;
      MODE_ABT: return BK_ABT;
      MODE_UND: return BK_UND;
      default:  return BK_SVC;
    endcase
  endfunction : bank_of

  // Valid stays up between back-to-back calls; the caller lowers it
  task automatic run(input logic [31:0] ins);
    instr_valid_i = 1'b1;
    instr_i = ins;
    tick();
  endtask : run

  // Reference entry: old status and return address go to the entered bank
  task automatic wait_exc(input logic [4:0] md, input logic [31:0] vec);
    int n;
    n = 0;
    while (taken !== 1'b1 && n < 6)
    begin
      tick();
      n++;
    end
    m_saved[bank_of(md)] = m_sw;
    m_link[bank_of(md)] = ret;
    m_sw = {m_sw[31:8], 1'b1, m_sw[6] | (md == MODE_FAST), 1'b0, md};
    chk({31'h0, taken}, 32'h1, "entry");
    chk(pct, vec, "vector");
    chk(csw, m_sw, "status on entry");
  endtask : wait_exc

  task automatic banks;
    tick();
    tick();
    chk(link, m_link[bank_of(m_sw[4:0])], "banked link");
    chk(ssw, m_saved[bank_of(m_sw[4:0])], "banked saved status");
  endtask : banks

  task automatic ret_instr(input logic [31:0] ins);
    int b;
    b = bank_of(m_sw[4:0]);
    run(ins);
    instr_valid_i = 1'b0;
    m_sw = m_saved[b];
    chk({31'h0, pcl}, 32'h1, "return load");
    chk(pct, m_link[b], "return target");
    chk(csw, m_sw, "restored status");
  endtask : ret_instr

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      bad_count++;
      $display("[FAIL] %0t timeout", $time);
      stop_test();
    end
  end

  initial
  begin
    ret = $urandom(90162);
    repeat (5) @(posedge clk_i);
    #1;
    rstn_i = 1'b1;
    m_sw = RESET_STATUS;
    chk(csw, m_sw, "reset status");
    chk({29'h0, pcl, taken, exec}, 32'h0, "reset pulses");
    foreach (ins_tab[i])
    begin
      run(ins_tab[i]);
      chk({29'h0, cls}, {29'h0, cls_tab[i]}, "class");
      chk({31'h0, exec}, 32'h1, "executed");
    end
    // Equal condition fails while the zero flag is clear
    run(32'h0081_0002);
    instr_valid_i = 1'b0;
    chk({31'h0, exec}, 32'h0, "cond fail");
    $display("test classes done");
    ret = $urandom;
    return_addr_i = ret;
    part.pulse(1'b1, 1'b1);
    wait_exc(MODE_ABT, VEC_ABT);
    tick();
    wait_exc(MODE_UND, VEC_UND);
    banks();
    ret_instr(32'he1b0_f00e);
    banks();
    ret_instr(32'he8fd_8000);
    $display("test entry and return done");
    part.levels(1'b1, 1'b1);
    repeat (10)
    begin
      tick();
      chk({31'h0, taken}, 32'h0, "masked interrupt");
    end
    part.levels(1'b0, 1'b0);
    repeat (5) tick();
    $display("test masking done");
    // Clear both masks, then fast beats normal when both lines rise together
    run(32'he321_f013);
    instr_valid_i = 1'b0;
    m_sw = {m_sw[31:8], 8'h13};
    chk(csw, m_sw, "masks cleared");
    ret = $urandom;
    return_addr_i = ret;
    part.levels(1'b1, 1'b1);
    wait_exc(MODE_FAST, VEC_FAST);
    part.levels(1'b0, 1'b0);
    banks();
    repeat (4) tick();
    ret_instr(32'he1b0_f00e);
    part.levels(1'b0, 1'b1);
    wait_exc(MODE_IRQ, VEC_IRQ);
    part.levels(1'b0, 1'b0);
    repeat (4) tick();
    ret_instr(32'he8fd_8000);
    $display("test interrupts done");
    ret = $urandom;
    return_addr_i = ret;
    run(32'hff00_0000);
    instr_valid_i = 1'b0;
    chk({31'h0, exec}, 32'h0, "never cond");
    repeat (3)
    begin
      tick();
      chk({31'h0, taken}, 32'h0, "no trap");
    end
    run(32'hef00_0000);
    instr_valid_i = 1'b0;
    wait_exc(MODE_SVC, VEC_TRAP);
    banks();
    $display("test trap done");
    repeat (8)
    begin
      reg_idx_i = 4'($urandom_range(7));
      tick();
      chk({27'h0, phys}, {28'h0, reg_idx_i}, "low reg");
      chk({31'h0, allowed}, 32'h1, "low allowed");
    end
    reg_idx_i = REG_SP;
    tick();
    chk({27'h0, phys}, {27'h0, PR_SVC}, "banked sp");
    reg_idx_i = REG_LR;
    tick();
    chk({27'h0, phys}, {27'h0, PR_SVC} + 32'h1, "banked link");
    run(32'he321_f033);
    instr_valid_i = 1'b0;
    m_sw = {m_sw[31:8], 8'h33};
    chk(csw, m_sw, "narrow state on");
    reg_idx_i = 4'h9;
    tick();
    chk({31'h0, allowed}, 32'h0, "high reg refused");
    hi_op = 1'b1;
    tick();
    chk({31'h0, allowed}, 32'h1, "high reg op allowed");
    hi_op = 1'b0;
    run(32'h0000_df00);
    instr_valid_i = 1'b0;
    chk({29'h0, cls}, {29'h0, CL_EXC}, "narrow trap class");
    wait_exc(MODE_SVC, VEC_TRAP);
    banks();
    $display("test register map done");
    stop_test();
  end
endmodule : tb
`default_nettype wire
